// ==== slpmc_map.svh ====
`ifndef SLPMC_MAP_SVH
`define SLPMC_MAP_SVH
// Register byte offsets
`define SLPMC_CTRL_OFS 12'h000
`define SLPMC_COMP_OFS 12'h004
`define SLPMC_STAT_OFS 12'h008
// Control register fields
`define SLPMC_MODE_HI_BIT 6
`define SLPMC_SLEEP_EN_BIT 5
`define SLPMC_MODE_LO_BIT 4
`define SLPMC_CTRL_MASK 8'h70
`define SLPMC_CTRL_RST 8'h00
// Comparator control fields
`define SLPMC_COMP_DIS_BIT 7
`define SLPMC_VREF_SEL_BIT 6
`define SLPMC_COMP_MASK 8'hC0
`define SLPMC_COMP_RST 8'h00
// Brown-out fuse code meaning disabled
`define SLPMC_BOD_OFF 3'b111
// Wake-up timing in clock cycles
`define SLPMC_HALT_CYC 4
`define SLPMC_STANDBY_RESUME_CYC 6
`define SLPMC_STANDBY_START_CYC (`SLPMC_STANDBY_RESUME_CYC - `SLPMC_HALT_CYC - 1)
`define SLPMC_PDOWN_START_CYC 6
`endif

// ==== slpmc_pkg.sv ====
package slpmc_pkg;
    typedef enum logic [2:0] {
        SLPMC_ACTIVE = 3'b000,
        SLPMC_IDLE = 3'b001,
        SLPMC_PDOWN = 3'b010,
        SLPMC_STANDBY = 3'b011,
        SLPMC_START = 3'b100,
        SLPMC_HALT = 3'b101,
        SLPMC_RESUME = 3'b110
    } slpmc_state_type;
    typedef enum logic [1:0] {
        SLPMC_MODE_IDLE = 2'b00,
        SLPMC_MODE_PDOWN = 2'b01,
        SLPMC_MODE_STANDBY = 2'b10,
        SLPMC_MODE_PDOWN2 = 2'b11
    } slpmc_mode_type;
endpackage : slpmc_pkg

// ==== slpmc_top.sv ====
`timescale 1ns/100ps
`include "slpmc_map.svh"
// What this block does
// - Sleep is entered only if sleep enable is one when sleep executes.
// - Mode field on bits 6,4: 00 idle, 01 power-down, 10 standby, 11 power-down.
// - Interrupt wake holds core four cycles past start-up, then services and resumes.
// - Register file and SRAM contents are kept through sleep and wake.
// - Any reset during sleep leaves sleep towards the reset vector.
// - Idle stops only core and flash clocks; others keep running.
// - Idle wakes on any enabled interrupt, external or internal.
// - Power-down stops the oscillator; external interrupts, start detect, watchdog stay.
// - Power-down halts all generated clocks.
// - Power-down wakes only on resets, start condition, interrupt zero level, pin change.
// - In deep sleep interrupt zero wakes only when level sensitive, never on edges.
// - Power-down wake is delayed by the start-up time set by PDOWN_START_CYC.
// - Code 10 with crystal gives standby: power-down but oscillator running.
// - Standby wake resumes operation within six cycles.
// - Comparator is powered down while its disable bit is set.
// - Non-idle sleep disables comparator; reference stays if comparator uses it.
// - A fuse-enabled brown-out detector stays active in all sleep modes.
// - Voltage reference is on only when brown-out or comparator needs it.
// - An enabled watchdog keeps running in all sleep modes.
// - With I/O clock stopped, input buffers off except wake-up inputs.
module slpmc_top #(
    parameter int CNT_W = 8,
    parameter int PDOWN_START_CYC = `SLPMC_PDOWN_START_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_instr,
    input wire logic irq_pending,
    input wire logic ext_interrupt_zero_edge_irq,
    input wire logic ext_interrupt_zero_level_mode,
    input wire logic ext_interrupt_zero_pin,
    input wire logic pin_change_irq,
    input wire logic serial_start_irq,
    input wire logic ext_reset_req,
    input wire logic wdt_reset_req,
    input wire logic bod_reset_req,
    input wire logic ext_crystal_sel,
    input wire logic [2:0] brownout_level_fuses,
    input wire logic wdt_enable,
    output slpmc_pkg::slpmc_state_type sleep_state,
    output logic core_clk_en,
    output logic flash_clk_en,
    output logic io_clk_en,
    output logic osc_en,
    output logic sleep_nop,
    output logic irq_service,
    output logic reset_vector_req,
    output logic comp_power_en,
    output logic vref_en,
    output logic bod_en,
    output logic wdt_run,
    output logic input_buf_en,
    output logic wake_buf_en,
    output logic data_retain
);
    import slpmc_pkg::*;

    localparam logic [CNT_W-1:0] HALT_CNT = CNT_W'(`SLPMC_HALT_CYC);
    localparam logic [CNT_W-1:0] SBY_CNT = CNT_W'(`SLPMC_STANDBY_START_CYC);
    localparam logic [CNT_W-1:0] PD_CNT = CNT_W'(PDOWN_START_CYC);
    localparam logic [CNT_W-1:0] ONE_CNT = CNT_W'(1);

    slpmc_state_type state;
    slpmc_state_type next_state;
    logic [7:0] ctrl;
    logic [7:0] comp;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic eiz_s1;
    logic eiz_s2;
    logic eiz_s3;
    logic eiz_low;
    logic [3:0] next_clk;
    logic reset_any;
    logic sleeping;
    logic deep_wake;
    logic idle_wake;
    logic apb_access;
    logic [31:0] rdata;
    logic rmapped;

    // Mode decode; standby needs a crystal, otherwise it falls back to power-down
    function automatic slpmc_state_type mode_target(input logic [1:0] mode, input logic xtal);
        slpmc_state_type t;
        t = SLPMC_PDOWN;
        unique case (slpmc_mode_type'(mode))
            SLPMC_MODE_IDLE: t = SLPMC_IDLE;
            SLPMC_MODE_PDOWN: t = SLPMC_PDOWN;
            SLPMC_MODE_STANDBY: t = xtal ? SLPMC_STANDBY : SLPMC_PDOWN;
            SLPMC_MODE_PDOWN2: t = SLPMC_PDOWN;
        endcase
        return t;
    endfunction : mode_target

    // Clock enables {core, flash, io, osc} for a state
    function automatic logic [3:0] clk_vec(input slpmc_state_type s);
        logic [3:0] v;
        v = 4'b1111;
        unique case (s)
            SLPMC_ACTIVE: v = 4'b1111;
            SLPMC_IDLE: v = 4'b0011;
            SLPMC_PDOWN: v = 4'b0000;
            SLPMC_STANDBY: v = 4'b0001;
            SLPMC_START: v = 4'b0001;
            SLPMC_HALT: v = 4'b0011;
            SLPMC_RESUME: v = 4'b1111;
            default: v = 4'b1111;
        endcase
        return v;
    endfunction : clk_vec

    // Interrupt zero pin: three stages, level accepted once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eiz_s1 <= 1'b1;
            eiz_s2 <= 1'b1;
            eiz_s3 <= 1'b1;
            eiz_low <= 1'b0;
        end else begin
            eiz_s1 <= ext_interrupt_zero_pin;
            eiz_s2 <= eiz_s1;
            eiz_s3 <= eiz_s2;
            if (eiz_s2 == eiz_s3) begin
                eiz_low <= !eiz_s3;
            end
        end
    end

    assign reset_any = ext_reset_req | wdt_reset_req | bod_reset_req;
    assign sleeping = (state != SLPMC_ACTIVE) && (state != SLPMC_RESUME);
    // interrupt zero only when level sensitive; edge requests are not looked at
    assign deep_wake = serial_start_irq | pin_change_irq |
        (ext_interrupt_zero_level_mode & eiz_low);
    // idle wake on any enabled interrupt
    assign idle_wake = irq_pending | ext_interrupt_zero_edge_irq | deep_wake;
    assign next_clk = clk_vec(next_state);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            SLPMC_ACTIVE: begin
                if (sleep_instr && ctrl[`SLPMC_SLEEP_EN_BIT]) begin
                    next_state = mode_target({ctrl[`SLPMC_MODE_HI_BIT], ctrl[`SLPMC_MODE_LO_BIT]},
                        ext_crystal_sel);
                end
            end
            SLPMC_IDLE: begin
                if (reset_any) begin
                    next_state = SLPMC_ACTIVE;
                end else if (idle_wake) begin
                    next_state = SLPMC_HALT;
                    next_cnt = HALT_CNT;
                end
            end
            SLPMC_PDOWN: begin
                if (reset_any) begin
                    next_state = SLPMC_ACTIVE;
                end else if (deep_wake) begin
                    next_state = SLPMC_START;
                    next_cnt = PD_CNT;
                end
            end
            SLPMC_STANDBY: begin
                if (reset_any) begin
                    next_state = SLPMC_ACTIVE;
                end else if (deep_wake) begin
                    // short restart keeps resume within six cycles
                    next_state = SLPMC_START;
                    next_cnt = SBY_CNT;
                end
            end
            SLPMC_START: begin
                if (reset_any) begin
                    next_state = SLPMC_ACTIVE;
                end else if (cnt <= ONE_CNT) begin
                    next_state = SLPMC_HALT;
                    next_cnt = HALT_CNT;
                end else begin
                    next_cnt = cnt - ONE_CNT;
                end
            end
            SLPMC_HALT: begin
                if (reset_any) begin
                    next_state = SLPMC_ACTIVE;
                end else if (cnt <= ONE_CNT) begin
                    next_state = SLPMC_RESUME;
                end else begin
                    next_cnt = cnt - ONE_CNT;
                end
            end
            SLPMC_RESUME: begin
                next_state = SLPMC_ACTIVE;
            end
            default: begin
                next_state = SLPMC_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= SLPMC_ACTIVE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Sequencing outputs, registered; state, clocks and irq_service from the next state so they line up with it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_state <= SLPMC_ACTIVE;
            core_clk_en <= 1'b1;
            flash_clk_en <= 1'b1;
            io_clk_en <= 1'b1;
            osc_en <= 1'b1;
            sleep_nop <= 1'b0;
            irq_service <= 1'b0;
            reset_vector_req <= 1'b0;
        end else begin
            sleep_state <= next_state;
            {core_clk_en, flash_clk_en, io_clk_en, osc_en} <= next_clk;
            sleep_nop <= (state == SLPMC_ACTIVE) && sleep_instr && !ctrl[`SLPMC_SLEEP_EN_BIT];
            irq_service <= (next_state == SLPMC_RESUME);
            reset_vector_req <= sleeping && reset_any;
        end
    end

    // Analog, watchdog and buffer controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_power_en <= 1'b0;
            vref_en <= 1'b0;
            bod_en <= 1'b0;
            wdt_run <= 1'b0;
            input_buf_en <= 1'b1;
            wake_buf_en <= 1'b1;
            data_retain <= 1'b1;
        end else begin
            // off whenever the I/O clock is off
            comp_power_en <= !comp[`SLPMC_COMP_DIS_BIT] && next_clk[1];
            bod_en <= (brownout_level_fuses != `SLPMC_BOD_OFF);
            vref_en <= (brownout_level_fuses != `SLPMC_BOD_OFF) ||
                (!comp[`SLPMC_COMP_DIS_BIT] && comp[`SLPMC_VREF_SEL_BIT]);
            wdt_run <= wdt_enable;
            input_buf_en <= next_clk[1];
            wake_buf_en <= 1'b1;
            // memories stay powered, only clocks stop
            data_retain <= 1'b1;
        end
    end

    // APB slave: one wait state, then pready with the registered answer
    assign apb_access = psel && penable && pready;

    always_comb begin
        rdata = 32'h0000_0000;
        rmapped = 1'b1;
        unique case (paddr)
            `SLPMC_CTRL_OFS: rdata = {24'h00_0000, ctrl};
            `SLPMC_COMP_OFS: rdata = {24'h00_0000, comp};
            `SLPMC_STAT_OFS: rdata = {29'h0000_0000, state};
            default: rmapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rdata;
                pslverr <= !rmapped || (pwrite && (paddr == `SLPMC_STAT_OFS));
            end else begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `SLPMC_CTRL_RST;
            comp <= `SLPMC_COMP_RST;
        end else if (apb_access && pwrite) begin
            if (paddr == `SLPMC_CTRL_OFS) begin
                ctrl <= pwdata[7:0] & `SLPMC_CTRL_MASK;
            end
            if (paddr == `SLPMC_COMP_OFS) begin
                comp <= pwdata[7:0] & `SLPMC_COMP_MASK;
            end
        end
    end

    property p_nop_stays;
        @(posedge pclk) disable iff (!presetn)
        (state == SLPMC_ACTIVE && sleep_instr && !ctrl[`SLPMC_SLEEP_EN_BIT])
            |=> (state == SLPMC_ACTIVE) && sleep_nop && core_clk_en;
    endproperty
    a_nop_stays: assert property (p_nop_stays) else $error("sleep entered with enable clear");

    property p_idle_clocks;
        @(posedge pclk) disable iff (!presetn)
        (state == SLPMC_IDLE) |-> !core_clk_en && !flash_clk_en && io_clk_en && osc_en;
    endproperty
    a_idle_clocks: assert property (p_idle_clocks) else $error("idle clock gating wrong");

    property p_pdown_clocks;
        @(posedge pclk) disable iff (!presetn)
        (state == SLPMC_PDOWN) |-> !core_clk_en && !io_clk_en && !osc_en && !input_buf_en;
    endproperty
    a_pdown_clocks: assert property (p_pdown_clocks) else $error("power-down clock left on");

    property p_standby_osc;
        @(posedge pclk) disable iff (!presetn)
        (state == SLPMC_STANDBY) |-> osc_en && !io_clk_en && !core_clk_en;
    endproperty
    a_standby_osc: assert property (p_standby_osc) else $error("standby oscillator wrong");

    property p_halt_four;
        @(posedge pclk) disable iff (!presetn || reset_any)
        $rose(state == SLPMC_HALT) |-> (state == SLPMC_HALT)[*4] ##1 irq_service;
    endproperty
    a_halt_four: assert property (p_halt_four) else $error("halt not four cycles");

    property p_standby_six;
        @(posedge pclk) disable iff (!presetn || reset_any)
        (state == SLPMC_STANDBY && deep_wake) |-> ##[1:6] (core_clk_en && irq_service);
    endproperty
    a_standby_six: assert property (p_standby_six) else $error("standby wake too slow");

    property p_edge_ignored;
        @(posedge pclk) disable iff (!presetn)
        (state == SLPMC_PDOWN) && !serial_start_irq && !pin_change_irq && !reset_any &&
            !(ext_interrupt_zero_level_mode && eiz_low) |=> (state == SLPMC_PDOWN);
    endproperty
    a_edge_ignored: assert property (p_edge_ignored) else $error("power-down left without source");

    property p_comp_deep_off;
        @(posedge pclk) disable iff (!presetn)
        (state == SLPMC_PDOWN || state == SLPMC_STANDBY) |-> !comp_power_en;
    endproperty
    a_comp_deep_off: assert property (p_comp_deep_off) else $error("comparator on in deep sleep");

    property p_bod_kept;
        @(posedge pclk) disable iff (!presetn)
        ($past(brownout_level_fuses) != `SLPMC_BOD_OFF) && sleeping |-> bod_en && vref_en;
    endproperty
    a_bod_kept: assert property (p_bod_kept) else $error("brown-out off in sleep");

    property p_reset_wake;
        @(posedge pclk) disable iff (!presetn)
        (sleeping && reset_any) |=> reset_vector_req && (state == SLPMC_ACTIVE) && !irq_service;
    endproperty
    a_reset_wake: assert property (p_reset_wake) else $error("reset in sleep not taken");

    property p_pdown_delay;
        @(posedge pclk) disable iff (!presetn || reset_any)
        (state == SLPMC_PDOWN && deep_wake) |=> !core_clk_en [*6];
    endproperty
    a_pdown_delay: assert property (p_pdown_delay) else $error("power-down wake too early");
endmodule : slpmc_top

// ==== slpmc_core_model.sv ====
`timescale 1ns/100ps
module slpmc_core_model (
    input wire logic pclk,
    input wire logic irq_service,
    output logic sleep_instr,
    output logic irq_pending,
    output logic ext_interrupt_zero_edge_irq,
    output logic ext_interrupt_zero_pin,
    output logic pin_change_irq,
    output logic serial_start_irq
);
    logic [3:0] src;
    assign irq_pending = src[0];
    assign pin_change_irq = src[1];
    assign serial_start_irq = src[2];
    // Pin is active low and idles high through its pull-up
    assign ext_interrupt_zero_pin = ~src[3];
    initial begin
        src = 4'h0;
        sleep_instr = 1'b0;
        ext_interrupt_zero_edge_irq = 1'b0;
    end
    task automatic do_sleep();
        @(posedge pclk);
        sleep_instr <= 1'b1;
        @(posedge pclk);
        sleep_instr <= 1'b0;
    endtask : do_sleep
    task automatic wake(input int sel, output int n);
        @(posedge pclk);
        src[sel] <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (irq_service !== 1'b1 && n < 60);
        src[sel] <= 1'b0;
    endtask : wake
    // Sources shown for a while and withdrawn; a deep sleep must ignore them
    task automatic stray(input logic [3:0] s, input logic e);
        @(posedge pclk);
        src <= s;
        ext_interrupt_zero_edge_irq <= e;
        repeat (12) @(posedge pclk);
        src <= 4'h0;
        ext_interrupt_zero_edge_irq <= 1'b0;
    endtask : stray
endmodule : slpmc_core_model

// ==== sleep_mode_controller_bench.sv ====
`timescale 1ns/100ps
`include "slpmc_map.svh"
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %s exp %h got %h", what, exp, got); end end
module sleep_mode_controller_bench;
    import slpmc_pkg::*;
    localparam int PSC = 2;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic sleep_instr, irq_pending, ext_interrupt_zero_edge_irq, ext_interrupt_zero_level_mode;
    logic ext_interrupt_zero_pin, pin_change_irq, serial_start_irq;
    logic ext_crystal_sel, wdt_enable, erv;
    logic [2:0] rq, brownout_level_fuses;
    slpmc_state_type sleep_state;
    logic core_clk_en, flash_clk_en, io_clk_en, osc_en, sleep_nop, irq_service;
    logic reset_vector_req, comp_power_en, vref_en, bod_en, wdt_run;
    logic input_buf_en, wake_buf_en, data_retain;
    int errors = 0;
    int checks = 0;
    int n;
    slpmc_top #(.PDOWN_START_CYC(PSC)) i_slpmc_top (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_instr(sleep_instr),
        .irq_pending(irq_pending), .ext_interrupt_zero_edge_irq(ext_interrupt_zero_edge_irq),
        .ext_interrupt_zero_level_mode(ext_interrupt_zero_level_mode),
        .ext_interrupt_zero_pin(ext_interrupt_zero_pin),
        .pin_change_irq(pin_change_irq), .serial_start_irq(serial_start_irq),
        .ext_reset_req(rq[0]), .wdt_reset_req(rq[1]), .bod_reset_req(rq[2]),
        .ext_crystal_sel(ext_crystal_sel), .brownout_level_fuses(brownout_level_fuses),
        .wdt_enable(wdt_enable), .sleep_state(sleep_state), .core_clk_en(core_clk_en),
        .flash_clk_en(flash_clk_en), .io_clk_en(io_clk_en), .osc_en(osc_en),
        .sleep_nop(sleep_nop), .irq_service(irq_service),
        .reset_vector_req(reset_vector_req), .comp_power_en(comp_power_en),
        .vref_en(vref_en), .bod_en(bod_en), .wdt_run(wdt_run), .input_buf_en(input_buf_en),
        .wake_buf_en(wake_buf_en), .data_retain(data_retain));
    slpmc_core_model i_slpmc_core_model (.pclk(pclk), .irq_service(irq_service),
        .sleep_instr(sleep_instr), .irq_pending(irq_pending),
        .ext_interrupt_zero_edge_irq(ext_interrupt_zero_edge_irq),
        .ext_interrupt_zero_pin(ext_interrupt_zero_pin), .pin_change_irq(pin_change_irq),
        .serial_start_irq(serial_start_irq));
    always #5 pclk = ~pclk;
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            errors++;
            give_verdict();
        end
    endtask : apb
    task automatic go_sleep(input logic [1:0] m);
        apb(1'b1, `SLPMC_CTRL_OFS, {1'b0, m[1], 1'b1, m[0], 4'h0});
        i_slpmc_core_model.do_sleep();
        @(posedge pclk);
    endtask : go_sleep
    task automatic wake_chk(input int sel, output int cnt);
        i_slpmc_core_model.wake(sel, cnt);
        if (cnt >= 60) begin
            errors++;
            give_verdict();
        end
        @(posedge pclk);
        `CHK("resumed", SLPMC_ACTIVE, sleep_state)
        `CHK("core back", 1'b1, core_clk_en)
        apb(1'b1, `SLPMC_CTRL_OFS, 8'h00);
    endtask : wake_chk
    task automatic deep_chk();
        `CHK("core off", 1'b0, core_clk_en)
        `CHK("io off", 1'b0, io_clk_en)
        `CHK("flash off", 1'b0, flash_clk_en)
        `CHK("inbuf off", 1'b0, input_buf_en)
        `CHK("wakebuf", 1'b1, wake_buf_en)
        `CHK("comp off", 1'b0, comp_power_en)
        `CHK("vref kept", 1'b1, vref_en)
        `CHK("bod on", 1'b1, bod_en)
        `CHK("wdt on", 1'b1, wdt_run)
        `CHK("retain", 1'b1, data_retain)
    endtask : deep_chk
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ext_interrupt_zero_level_mode = 1'b0;
        ext_crystal_sel = 1'b0;
        wdt_enable = 1'b0;
        rq = 3'h0;
        brownout_level_fuses = `SLPMC_BOD_OFF;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK("state rst", SLPMC_ACTIVE, sleep_state)
        `CHK("comp pwr", 1'b1, comp_power_en)
        `CHK("bod off", 1'b0, bod_en)
        `CHK("vref off", 1'b0, vref_en)
        `CHK("wdt off", 1'b0, wdt_run)
        apb(1'b0, `SLPMC_CTRL_OFS, 8'h00);
        `CHK("ctrl rst", {24'h00_0000, `SLPMC_CTRL_RST}, rdv)
        apb(1'b1, `SLPMC_CTRL_OFS, 8'hFF);
        apb(1'b0, `SLPMC_CTRL_OFS, 8'h00);
        `CHK("ctrl mask", {24'h00_0000, `SLPMC_CTRL_MASK}, rdv)
        apb(1'b1, `SLPMC_CTRL_OFS, 8'h00);
        apb(1'b0, 12'h00C, 8'h00);
        `CHK("unmapped", 1'b1, erv)
        apb(1'b1, `SLPMC_STAT_OFS, 8'h55);
        `CHK("stat ro", 1'b1, erv)
        apb(1'b1, `SLPMC_COMP_OFS, 8'hFF);
        apb(1'b0, `SLPMC_COMP_OFS, 8'h00);
        `CHK("comp mask", {24'h00_0000, `SLPMC_COMP_MASK}, rdv)
        repeat (2) @(posedge pclk);
        `CHK("comp down", 1'b0, comp_power_en)
        `CHK("vref unused", 1'b0, vref_en)
        apb(1'b1, `SLPMC_COMP_OFS, 8'h40);
        repeat (2) @(posedge pclk);
        `CHK("vref comp", 1'b1, vref_en)
        brownout_level_fuses <= 3'b101;
        wdt_enable <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK("bod fuse", 1'b1, bod_en)
        `CHK("wdt run", 1'b1, wdt_run)
        $display("test registers done");
        apb(1'b1, `SLPMC_CTRL_OFS, 8'h10);
        i_slpmc_core_model.do_sleep();
        @(posedge pclk);
        `CHK("nop pulse", 1'b1, sleep_nop)
        `CHK("nop state", SLPMC_ACTIVE, sleep_state)
        `CHK("nop core", 1'b1, core_clk_en)
        $display("test no-op done");
        go_sleep(2'b00);
        `CHK("idle", SLPMC_IDLE, sleep_state)
        `CHK("idle core", 1'b0, core_clk_en)
        `CHK("idle flash", 1'b0, flash_clk_en)
        `CHK("idle io", 1'b1, io_clk_en)
        `CHK("idle osc", 1'b1, osc_en)
        `CHK("idle comp", 1'b1, comp_power_en)
        apb(1'b0, `SLPMC_STAT_OFS, 8'h00);
        `CHK("stat idle", 32'(SLPMC_IDLE), rdv)
        wake_chk(0, n);
        `CHK("idle wake", 6, n)
        $display("test idle done");
        for (int i = 0; i < 2; i++) begin
            go_sleep(i == 0 ? 2'b01 : 2'b11);
            `CHK("pdown", SLPMC_PDOWN, sleep_state)
            `CHK("pdown osc", 1'b0, osc_en)
            deep_chk();
            i_slpmc_core_model.stray(4'b1001, 1'b1);
            `CHK("no stray", SLPMC_PDOWN, sleep_state)
            wake_chk(i + 1, n);
            `CHK("pdown delay", PSC + 6, n)
        end
        ext_interrupt_zero_level_mode <= 1'b1;
        go_sleep(2'b01);
        wake_chk(3, n);
        `CHK("level wake", 1'b1, n > PSC + 6 && n < PSC + 12)
        $display("test power-down done");
        ext_crystal_sel <= 1'b1;
        go_sleep(2'b10);
        `CHK("standby", SLPMC_STANDBY, sleep_state)
        `CHK("stby osc", 1'b1, osc_en)
        deep_chk();
        wake_chk(2, n);
        `CHK("stby wake", 7, n)
        ext_crystal_sel <= 1'b0;
        $display("test standby done");
        for (int r = 0; r < 3; r++) begin
            go_sleep(2'b10);
            `CHK("no crystal", SLPMC_PDOWN, sleep_state)
            @(posedge pclk);
            rq[r] <= 1'b1;
            @(posedge pclk);
            rq[r] <= 1'b0;
            @(posedge pclk);
            `CHK("rst wake", SLPMC_ACTIVE, sleep_state)
            `CHK("rst vector", 1'b1, reset_vector_req)
            `CHK("rst no isr", 1'b0, irq_service)
            apb(1'b1, `SLPMC_CTRL_OFS, 8'h00);
        end
        $display("test reset wake done");
        give_verdict();
    end
endmodule : sleep_mode_controller_bench
